// ### rtl/lookup_engine_ctrl_irq_regs.sv
// Lookup engine control, aging and table event registers on AXI4-Lite
// Function
// - Trap reserved multicast to host when double-tagged
// - Dynamic hit ANDs table and VLAN maps
// - Static hit ANDs table and VLAN maps
// - Flush scope selects dynamic, static or both
// - Scope governs both flush operations
// - Scope reads 00 once flush completes
// - Priority from DA, SA, higher or lower
// - Age period times age count gives seconds
// - Learn fail when bucket all static
// - Almost full on static write into 2-3
// - Write fail when static write meets full
// - Status bits sticky until written one
// - Summary status is OR of status bits
// - Mask bit one disables, resets to one
// - Whole-table flush bit self-clears when done
// - Spanning-tree flush bit self-clears when done
// - Aging runs only when aging enable set
`timescale 1ns/1ps
`default_nettype none
`include "lookup_engine_defs.svh"

module lookup_engine_ctrl_irq_regs
  import lookup_engine_pkg::*;
#(
  parameter int unsigned TICKS_PER_SECOND = `CLOCK_HZ * `AGE_UNIT_S,
  parameter int unsigned HOST_PORT        = 6
) (
  input  wire logic                         ref_clk,
  input  wire logic                         rst,
  input  wire logic [31:0]                  s_axi_awaddr,
  input  wire logic                         s_axi_awvalid,
  output logic                              s_axi_awready,
  input  wire logic [31:0]                  s_axi_wdata,
  input  wire logic [3:0]                   s_axi_wstrb,
  input  wire logic                         s_axi_wvalid,
  output logic                              s_axi_wready,
  output logic [1:0]                        s_axi_bresp,
  output logic                              s_axi_bvalid,
  input  wire logic                         s_axi_bready,
  input  wire logic [31:0]                  s_axi_araddr,
  input  wire logic                         s_axi_arvalid,
  output logic                              s_axi_arready,
  output logic [31:0]                       s_axi_rdata,
  output logic [1:0]                        s_axi_rresp,
  output logic                              s_axi_rvalid,
  input  wire logic                         s_axi_rready,
  input  wire fwd_lookup_t                  fwdLookup,
  output logic [`PORT_MAP_W-1:0]            egressPortMap,
  input  wire logic [`PRIO_W-1:0]           daPriority,
  input  wire logic [`PRIO_W-1:0]           saPriority,
  output logic [`PRIO_W-1:0]                address_based_priority,
  output logic                              flushRequest,
  output logic                              flushSpanningTreeOnly,
  output logic                              flushDynamic,
  output logic                              flushStatic,
  input  wire logic                         flushDone,
  input  wire logic [`AGE_COUNT_W-1:0]      entryAgeCount,
  output logic [`AGE_COUNT_W+7:0]           entryAgingSeconds,
  output logic                              agingEnable,
  output logic                              ageSecondTick,
  input  wire table_event_t                 tableEvent,
  output logic                              lookup_engine_summary_irq,
  output logic                              lookupTableIrq
);

  localparam int unsigned TICK_W = $clog2(TICKS_PER_SECOND + 1);
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  function automatic logic [`REG_INDEX_W:0] decodeIndex(
    input logic [31:0] addr
  );
    decodeIndex = {|addr[31:14] | |addr[1:0], addr[13:2]};
  endfunction : decodeIndex

  function automatic logic isMapped(input logic [`REG_INDEX_W:0] idx);
    isMapped = !idx[`REG_INDEX_W] &&
               (idx[`REG_INDEX_W-1:0] >= `IDX_CONTROL_ONE) &&
               (idx[`REG_INDEX_W-1:0] <= `IDX_SUMMARY_STATUS);
  endfunction : isMapped

  logic [7:0]               controlOne_q;
  logic [7:0]               lookup_engine_control_two_q;
  logic [7:0]               entry_age_period_q;
  logic [2:0]               lookup_table_event_status_q;
  logic [2:0]               lookup_table_event_mask_q;
  logic                     awHeld_q;
  logic [31:0]              awAddr_q;
  logic                     wHeld_q;
  logic [31:0]              wData_q;
  logic [3:0]               wStrb_q;
  logic [`REG_INDEX_W:0]    wrIdx;
  logic                     wrFire;
  logic                     wrLane0;
  logic [`REG_INDEX_W:0]    rdIdx;
  logic                     rdFire;
  logic [7:0]               rdByte;
  flush_state_t             flushState_q;
  logic                     flushFinish;
  logic [TICK_W-1:0]        tickCount_q;
  logic [2:0]               eventHit;
  flush_scope_t             scope;
  prio_select_t             prioSel;

  // Write address and data may arrive in either order
  assign s_axi_awready = !awHeld_q;
  assign s_axi_wready  = !wHeld_q;
  assign wrFire        = awHeld_q && wHeld_q && !s_axi_bvalid;
  assign wrIdx         = decodeIndex(awAddr_q);
  assign wrLane0       = wrFire && wStrb_q[0];

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      awHeld_q <= 1'b0;
      awAddr_q <= 32'h0000_0000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      awHeld_q <= 1'b1;
      awAddr_q <= s_axi_awaddr;
    end else if (wrFire) begin
      awHeld_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wHeld_q <= 1'b0;
      wData_q <= 32'h0000_0000;
      wStrb_q <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wHeld_q <= 1'b1;
      wData_q <= s_axi_wdata;
      wStrb_q <= s_axi_wstrb;
    end else if (wrFire) begin
      wHeld_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wrFire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= isMapped(wrIdx) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read side: one outstanding read, answered the cycle after acceptance
  assign s_axi_arready = !s_axi_rvalid;
  assign rdFire        = s_axi_arvalid && s_axi_arready;
  assign rdIdx         = decodeIndex(s_axi_araddr);

  always_comb begin
    rdByte = 8'h00;
    case (rdIdx)
      {1'b0, `IDX_CONTROL_ONE}:    rdByte = controlOne_q;
      {1'b0, `IDX_CONTROL_TWO}:    rdByte = lookup_engine_control_two_q;
      {1'b0, `IDX_AGE_PERIOD}:     rdByte = entry_age_period_q;
      {1'b0, `IDX_EVENT_STATUS}:   rdByte = {5'h00,
                                             lookup_table_event_status_q};
      {1'b0, `IDX_EVENT_MASK}:     rdByte = {5'h00,
                                             lookup_table_event_mask_q};
      {1'b0, `IDX_SUMMARY_STATUS}: rdByte = {7'h00,
                                             lookup_engine_summary_irq};
      default:                     rdByte = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (rdFire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h00_0000, rdByte};
      s_axi_rresp  <= isMapped(rdIdx) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Flush triggers self-clear; a fresh software trigger beats the clear
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      controlOne_q <= `CONTROL_ONE_RESET;
    end else begin
      if (flushFinish) begin
        controlOne_q[`C1_FLUSH_ALL] <= 1'b0;
        controlOne_q[`C1_FLUSH_STP] <= 1'b0;
      end
      if (wrLane0 && wrIdx == {1'b0, `IDX_CONTROL_ONE}) begin
        controlOne_q <= wData_q[7:0] |
                        (flushFinish ? 8'h00 :
                         (controlOne_q & 8'h30));
      end
    end
  end

  // Scope field is cleared by hardware once a flush has run
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      lookup_engine_control_two_q <= `CONTROL_TWO_RESET;
    end else if (wrLane0 && wrIdx == {1'b0, `IDX_CONTROL_TWO}) begin
      lookup_engine_control_two_q <= wData_q[7:0];
    end else if (flushFinish) begin
      lookup_engine_control_two_q[`C2_SCOPE_HI:`C2_SCOPE_LO] <= 2'b00;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      entry_age_period_q <= `AGE_PERIOD_RESET;
    end else if (wrLane0 && wrIdx == {1'b0, `IDX_AGE_PERIOD}) begin
      entry_age_period_q <= wData_q[7:0];
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      lookup_table_event_mask_q <= `EVENT_MASK_RESET;
    end else if (wrLane0 && wrIdx == {1'b0, `IDX_EVENT_MASK}) begin
      lookup_table_event_mask_q <= wData_q[2:0];
    end
  end

  assign scope   = flush_scope_t'(
    lookup_engine_control_two_q[`C2_SCOPE_HI:`C2_SCOPE_LO]);
  assign prioSel = prio_select_t'(
    lookup_engine_control_two_q[`C2_PRIO_HI:`C2_PRIO_LO]);

  // Flush sequencer; a trigger with scope 00 has nothing to do
  assign flushFinish = (flushState_q == FLUSH_RUN && flushDone) ||
                       (flushState_q == FLUSH_IDLE &&
                        (controlOne_q[`C1_FLUSH_ALL] ||
                         controlOne_q[`C1_FLUSH_STP]) &&
                        scope == SCOPE_NONE);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      flushState_q          <= FLUSH_IDLE;
      flushRequest          <= 1'b0;
      flushSpanningTreeOnly <= 1'b0;
      flushDynamic          <= 1'b0;
      flushStatic           <= 1'b0;
    end else begin
      case (flushState_q)
        FLUSH_IDLE: begin
          if ((controlOne_q[`C1_FLUSH_ALL] ||
               controlOne_q[`C1_FLUSH_STP]) &&
              scope != SCOPE_NONE) begin
            flushState_q          <= FLUSH_RUN;
            flushRequest          <= 1'b1;
            flushSpanningTreeOnly <= !controlOne_q[`C1_FLUSH_ALL];
            flushDynamic          <= scope == SCOPE_DYNAMIC ||
                                     scope == SCOPE_BOTH;
            flushStatic           <= scope == SCOPE_STATIC ||
                                     scope == SCOPE_BOTH;
          end
        end
        FLUSH_RUN: begin
          if (flushDone) begin
            flushState_q <= FLUSH_IDLE;
            flushRequest <= 1'b0;
            flushDynamic <= 1'b0;
            flushStatic  <= 1'b0;
          end
        end
        default: begin
          flushState_q <= FLUSH_IDLE;
          flushRequest <= 1'b0;
        end
      endcase
    end
  end

  // Table events; a new event wins over a clear in the same cycle
  assign eventHit[`EV_LEARN_FAIL]  = tableEvent.learnAttempt &&
    tableEvent.bucketStaticCount == `BUCKET_FULL;
  assign eventHit[`EV_ALMOST_FULL] = tableEvent.staticWrite &&
    (tableEvent.bucketValidCount == `ALMOST_FULL_LO ||
     tableEvent.bucketValidCount == `ALMOST_FULL_HI);
  assign eventHit[`EV_WRITE_FAIL]  = tableEvent.staticWrite &&
    tableEvent.bucketValidCount >= `BUCKET_FULL;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      lookup_table_event_status_q <= 3'h0;
    end else begin
      if (wrLane0 && wrIdx == {1'b0, `IDX_EVENT_STATUS}) begin
        lookup_table_event_status_q <= (lookup_table_event_status_q &
                                        ~wData_q[2:0]) | eventHit;
      end else begin
        lookup_table_event_status_q <= lookup_table_event_status_q |
                                       eventHit;
      end
    end
  end

  assign lookup_engine_summary_irq = |lookup_table_event_status_q;
  assign lookupTableIrq = |(lookup_table_event_status_q &
                            ~lookup_table_event_mask_q);

  // Egress port map; trap only meaningful under double tagging
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      egressPortMap <= '0;
    end else if (lookup_engine_control_two_q[`C2_MCAST_TRAP] &&
                 fwdLookup.doubleTagMode && fwdLookup.reservedMcast) begin
      egressPortMap <= `PORT_MAP_W'(1) << HOST_PORT;
    end else if (fwdLookup.dynHit &&
                 lookup_engine_control_two_q[`C2_DYN_VLAN_FILT]) begin
      egressPortMap <= fwdLookup.tablePortMap &
                       fwdLookup.vlanPortMap;
    end else if (fwdLookup.staticHit &&
                 lookup_engine_control_two_q[`C2_STAT_VLAN_FILT]) begin
      egressPortMap <= fwdLookup.tablePortMap &
                       fwdLookup.vlanPortMap;
    end else begin
      egressPortMap <= fwdLookup.tablePortMap;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      address_based_priority <= '0;
    end else begin
      case (prioSel)
        PRIO_FROM_DA: address_based_priority <= daPriority;
        PRIO_FROM_SA: address_based_priority <= saPriority;
        PRIO_HIGHER:  address_based_priority <=
          (daPriority > saPriority) ? daPriority : saPriority;
        PRIO_LOWER:   address_based_priority <=
          (daPriority < saPriority) ? daPriority : saPriority;
        default:      address_based_priority <= daPriority;
      endcase
    end
  end

  // Aging time per entry, in seconds
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      entryAgingSeconds <= '0;
    end else begin
      entryAgingSeconds <= (`AGE_COUNT_W+8)'(entry_age_period_q) *
                           (`AGE_COUNT_W+8)'(entryAgeCount);
    end
  end
  assign agingEnable = controlOne_q[`C1_AGING_EN];

  // Seconds tick held off while aging is disabled
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tickCount_q   <= '0;
      ageSecondTick <= 1'b0;
    end else if (!agingEnable) begin
      tickCount_q   <= '0;
      ageSecondTick <= 1'b0;
    end else if (tickCount_q == TICK_W'(TICKS_PER_SECOND - 1)) begin
      tickCount_q   <= '0;
      ageSecondTick <= 1'b1;
    end else begin
      tickCount_q   <= tickCount_q + TICK_W'(1);
      ageSecondTick <= 1'b0;
    end
  end

endmodule : lookup_engine_ctrl_irq_regs
`default_nettype wire

// ### rtl/lookup_engine_defs.svh
// Register indices, field positions, reset values and timing counts
`ifndef LOOKUP_ENGINE_DEFS_SVH
`define LOOKUP_ENGINE_DEFS_SVH

`define REG_INDEX_W        12
`define IDX_CONTROL_ONE    12'h311
`define IDX_CONTROL_TWO    12'h312
`define IDX_AGE_PERIOD     12'h313
`define IDX_EVENT_STATUS   12'h314
`define IDX_EVENT_MASK     12'h315
`define IDX_SUMMARY_STATUS 12'h316

`define CONTROL_ONE_RESET  8'h0c
`define CONTROL_TWO_RESET  8'h00
`define AGE_PERIOD_RESET   8'h4b
`define EVENT_MASK_RESET   3'h7

`define C1_FLUSH_ALL       5
`define C1_FLUSH_STP       4
`define C1_AGING_EN        2
`define C2_MCAST_TRAP      6
`define C2_DYN_VLAN_FILT   5
`define C2_STAT_VLAN_FILT  4
`define C2_SCOPE_HI        3
`define C2_SCOPE_LO        2
`define C2_PRIO_HI         1
`define C2_PRIO_LO         0

`define EV_LEARN_FAIL      2
`define EV_ALMOST_FULL     1
`define EV_WRITE_FAIL      0

`define PORT_MAP_W         7
`define PRIO_W             3
`define BUCKET_CNT_W       3
`define AGE_COUNT_W        3
`define ALMOST_FULL_LO     3'h2
`define ALMOST_FULL_HI     3'h3
`define BUCKET_FULL        3'h4

`define CLOCK_HZ           250000000
`define AGE_UNIT_S         1

`endif

// ### rtl/lookup_engine_pkg.sv
// Types shared by the lookup engine control register block
`include "lookup_engine_defs.svh"

package lookup_engine_pkg;

  typedef enum logic [1:0] {
    SCOPE_NONE,
    SCOPE_DYNAMIC,
    SCOPE_STATIC,
    SCOPE_BOTH
  } flush_scope_t;

  typedef enum logic [1:0] {
    PRIO_FROM_DA,
    PRIO_FROM_SA,
    PRIO_HIGHER,
    PRIO_LOWER
  } prio_select_t;

  typedef enum {
    FLUSH_IDLE,
    FLUSH_RUN
  } flush_state_t;

  typedef struct packed {
    logic                     dynHit;
    logic                     staticHit;
    logic                     reservedMcast;
    logic                     doubleTagMode;
    logic [`PORT_MAP_W-1:0]   tablePortMap;
    logic [`PORT_MAP_W-1:0]   vlanPortMap;
  } fwd_lookup_t;

  typedef struct packed {
    logic                      staticWrite;
    logic                      learnAttempt;
    logic [`BUCKET_CNT_W-1:0]  bucketValidCount;
    logic [`BUCKET_CNT_W-1:0]  bucketStaticCount;
  } table_event_t;

endpackage : lookup_engine_pkg

// ### dv/lookup_engine_ctrl_irq_regs_asserts.sv
// Port checks for the lookup engine register block
`timescale 1ns/1ps
`default_nettype none
`include "lookup_engine_defs.svh"

module lookup_engine_ctrl_irq_regs_asserts
  import lookup_engine_pkg::*;
#(
  parameter int unsigned HOST_PORT = 6
) (
  input wire logic                    ref_clk,
  input wire logic                    rst,
  input wire logic                    s_axi_bvalid,
  input wire fwd_lookup_t             fwdLookup,
  input wire logic [`PORT_MAP_W-1:0]  egressPortMap,
  input wire logic [`PRIO_W-1:0]      daPriority,
  input wire logic [`PRIO_W-1:0]      saPriority,
  input wire logic [`PRIO_W-1:0]      address_based_priority,
  input wire logic                    flushRequest,
  input wire logic                    flushDynamic,
  input wire logic                    flushStatic,
  input wire logic                    flushDone,
  input wire logic                    agingEnable,
  input wire logic                    ageSecondTick,
  input wire table_event_t            tableEvent,
  input wire logic                    lookup_engine_summary_irq,
  input wire logic                    lookupTableIrq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // Trap gives host only, otherwise never wider than the table map
  property p_egress;
    ((egressPortMap & ~$past(fwdLookup.tablePortMap)) == '0) ||
    (egressPortMap == (`PORT_MAP_W'(1) << HOST_PORT));
  endproperty
  // Output still holds its reset value on the first edge after release
  property p_prio;
    !$past(rst) |->
    (address_based_priority == $past(daPriority)) ||
    (address_based_priority == $past(saPriority));
  endproperty
  property p_event;
    (tableEvent.learnAttempt && tableEvent.bucketStaticCount == 3'h4) ||
    (tableEvent.staticWrite && tableEvent.bucketValidCount >= 3'h2)
    |=> lookup_engine_summary_irq;
  endproperty
  // Only a committed write may clear a sticky bit
  property p_sticky;
    $fell(lookup_engine_summary_irq) |-> $rose(s_axi_bvalid);
  endproperty
  // Raised only by a fresh table event or by a committed mask write
  property p_irq;
    $rose(lookupTableIrq) |-> lookup_engine_summary_irq &&
      ($past(tableEvent.learnAttempt || tableEvent.staticWrite) ||
       $rose(s_axi_bvalid));
  endproperty
  property p_scope;
    flushRequest |-> (flushDynamic || flushStatic);
  endproperty
  property p_flush_end;
    $fell(flushRequest) |-> $past(flushDone);
  endproperty
  // Enable seen one cycle late, the tick is registered
  property p_tick;
    ageSecondTick |-> $past(agingEnable) ##1 !ageSecondTick;
  endproperty

  a_egress: assert property (p_egress)
    else $error("egress map not derived from lookup");
  a_prio: assert property (p_prio)
    else $error("priority not from DA or SA");
  a_event: assert property (p_event)
    else $error("table event did not set status");
  a_sticky: assert property (p_sticky)
    else $error("status cleared without a write");
  a_irq: assert property (p_irq)
    else $error("interrupt without status");
  a_scope: assert property (p_scope)
    else $error("flush without scope");
  a_flush_end: assert property (p_flush_end)
    else $error("flush ended without done");
  a_tick: assert property (p_tick)
    else $error("aging tick while aging disabled");

  c_flush: cover property ($rose(flushRequest));
  c_irq: cover property ($rose(lookupTableIrq));
  c_trap: cover property (egressPortMap == (`PORT_MAP_W'(1) << HOST_PORT));
endmodule : lookup_engine_ctrl_irq_regs_asserts

bind lookup_engine_ctrl_irq_regs lookup_engine_ctrl_irq_regs_asserts
  #(.HOST_PORT(HOST_PORT)) u_asserts (.*);

`default_nettype wire

// ### dv/lookup_engine_ctrl_irq_regs_bench.sv
// Self-checking bench for the lookup engine register block
`timescale 1ns/1ps
`default_nettype none
`include "lookup_engine_defs.svh"

module lookup_engine_ctrl_irq_regs_bench
  import lookup_engine_pkg::*;
;
  typedef struct packed {
    logic [31:0] a;
    logic [7:0]  w, r;
    logic [1:0]  e;
    logic [3:0]  f;
    logic [6:0]  eg;
    logic [2:0]  pr;
  } row_t;
  logic ref_clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready, flushRequest;
  logic flushSpanningTreeOnly, flushDynamic, flushStatic, flushDone;
  logic agingEnable, ageSecondTick, lookup_engine_summary_irq;
  logic lookupTableIrq;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [6:0]  egressPortMap;
  logic [2:0]  daPriority, saPriority, address_based_priority;
  logic [2:0]  entryAgeCount;
  logic [10:0] entryAgingSeconds;
  fwd_lookup_t  fwdLookup;
  table_event_t tableEvent;
  int failures, nTests, k;
  // Rows start with control-two at zero; its rows then walk the modes
  row_t rows [10] = '{
    '{32'hc4c, 8'ha5, 8'ha5, 2'h0, 4'h8, 7'h3c, 3'h5},
    '{32'hc54, 8'hff, 8'h07, 2'h0, 4'h8, 7'h3c, 3'h5},
    '{32'hc50, 8'hff, 8'h00, 2'h0, 4'h8, 7'h3c, 3'h5},
    '{32'hc60, 8'h12, 8'h00, 2'h2, 4'h8, 7'h3c, 3'h5},
    '{32'hc48, 8'h30, 8'h30, 2'h0, 4'h8, 7'h24, 3'h5},
    '{32'hc48, 8'h21, 8'h21, 2'h0, 4'h8, 7'h24, 3'h2},
    '{32'hc48, 8'h12, 8'h12, 2'h0, 4'h4, 7'h24, 3'h5},
    '{32'hc48, 8'h13, 8'h13, 2'h0, 4'h8, 7'h3c, 3'h2},
    '{32'hc48, 8'h40, 8'h40, 2'h0, 4'hb, 7'h40, 3'h5},
    '{32'hc48, 8'hc0, 8'hc0, 2'h0, 4'ha, 7'h3c, 3'h5}};
  logic [11:0] resetAddr [6] = '{12'hc44, 12'hc48, 12'hc4c, 12'hc50,
                                 12'hc54, 12'hc58};
  logic [7:0]  resetVal [6] = '{8'h0c, 8'h00, 8'h4b, 8'h00, 8'h07, 8'h00};
  table_event_t evs [5] = '{'{1'b0, 1'b1, 3'h4, 3'h4},
    '{1'b0, 1'b1, 3'h4, 3'h3}, '{1'b1, 1'b0, 3'h1, 3'h0},
    '{1'b1, 1'b0, 3'h3, 3'h0}, '{1'b1, 1'b0, 3'h4, 3'h0}};
  logic [7:0]  evExp [5] = '{8'h04, 8'h00, 8'h00, 8'h02, 8'h01};

  lookup_engine_ctrl_irq_regs #(.TICKS_PER_SECOND(8))
    u_lookup_engine_ctrl_irq_regs (.*);

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    nTests++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : cmp

  task automatic wr(input logic [31:0] a, input logic [7:0] d,
                    input logic [1:0] er);
    bit aw, w;
    @(posedge ref_clk);
    s_axi_awaddr <= a; s_axi_wdata <= {24'h0, d}; s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
    aw = 0; w = 0;
    while (!(aw && w)) begin
      @(negedge ref_clk);
      if (s_axi_awvalid && s_axi_awready) aw = 1;
      if (s_axi_wvalid && s_axi_wready) w = 1;
      @(posedge ref_clk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end
    do @(negedge ref_clk); while (s_axi_bvalid !== 1'b1);
    cmp(s_axi_bresp, er);
    @(posedge ref_clk);
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [31:0] a, input logic [7:0] d,
                    input logic [1:0] er);
    @(posedge ref_clk);
    s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
    do @(negedge ref_clk); while (s_axi_arready !== 1'b1);
    @(posedge ref_clk);
    s_axi_arvalid <= 1'b0;
    do @(negedge ref_clk); while (s_axi_rvalid !== 1'b1);
    cmp(s_axi_rdata, {24'h0, d});
    cmp(s_axi_rresp, er);
    @(posedge ref_clk);
    s_axi_rready <= 1'b0;
  endtask : rd

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", nTests, failures);
    if (failures == 0 && nTests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : conclude

  // Generous span, the sequence needs only a few hundred cycles
  initial begin
    #200000;
    failures++;
    conclude();
  end

  initial begin
    rst = 1'b1; {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, flushDone} = '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_wstrb} = '0;
    fwdLookup = '0; tableEvent = '0; daPriority = 3'h5;
    saPriority = 3'h2; entryAgeCount = 3'h5;
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    for (int i = 0; i < 6; i++)
      rd({20'h0, resetAddr[i]}, resetVal[i], 2'h0);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w, rows[i].e);
      rd(rows[i].a, rows[i].r, rows[i].e);
      fwdLookup <= {rows[i].f, 7'h3c, 7'h66};
      @(posedge ref_clk);
      @(negedge ref_clk);
      cmp(egressPortMap, rows[i].eg);
      cmp(address_based_priority, rows[i].pr);
    end
    cmp(entryAgingSeconds, 11'h339);
    for (int s = 0; s < 4; s++) for (int b = 4; b < 6; b++) begin
      wr(32'hc48, 8'(s << 2), 2'h0);
      wr(32'hc44, 8'h0c | 8'(1 << b), 2'h0);
      @(negedge ref_clk);
      cmp(flushRequest, s != 0);
      if (s != 0) begin
        cmp({flushStatic, flushDynamic}, s);
        cmp(flushSpanningTreeOnly, b == 4);
        rd(32'hc48, 8'(s << 2), 2'h0);
        @(posedge ref_clk);
        flushDone <= 1'b1;
        @(posedge ref_clk);
        flushDone <= 1'b0;
      end
      rd(32'hc48, 8'h00, 2'h0);
      rd(32'hc44, 8'h0c, 2'h0);
      cmp(flushRequest, 1'b0);
    end
    wr(32'hc54, 8'h00, 2'h0);
    foreach (evs[i]) begin
      @(posedge ref_clk);
      tableEvent <= evs[i];
      @(posedge ref_clk);
      tableEvent <= '0;
      repeat (3) @(negedge ref_clk);
      cmp(lookup_engine_summary_irq, evExp[i] != 0);
      cmp(lookupTableIrq, evExp[i] != 0);
      rd(32'hc50, evExp[i], 2'h0);
      wr(32'hc50, 8'h07, 2'h0);
      rd(32'hc50, 8'h00, 2'h0);
    end
    wr(32'hc54, 8'h07, 2'h0);
    @(posedge ref_clk);
    tableEvent <= evs[0];
    @(posedge ref_clk);
    tableEvent <= '0;
    @(negedge ref_clk);
    cmp({lookup_engine_summary_irq, lookupTableIrq}, 2'b10);
    wr(32'hc50, 8'h04, 2'h0);
    @(negedge ref_clk);
    cmp(lookup_engine_summary_irq, 1'b0);
    for (int en = 1; en >= 0; en--) begin
      wr(32'hc44, en ? 8'h0c : 8'h08, 2'h0);
      cmp(agingEnable, en);
      k = 0;
      repeat (32) begin
        @(negedge ref_clk);
        if (ageSecondTick === 1'b1) k++;
      end
      cmp(k, en ? 4 : 0);
    end
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    rd(32'hc4c, 8'h4b, 2'h0);
    rd(32'hc44, 8'h0c, 2'h0);
    conclude();
  end
endmodule : lookup_engine_ctrl_irq_regs_bench

`default_nettype wire
